// ==== hdl/hpds_pkg.sv ====
// Shared constants for the hardware power down sequencer
package hpds_pkg;

	// Machine cycle length in core clocks
	localparam int unsigned MC_CLKS       = 12;
	// Internal reset length in machine cycles on power down entry
	localparam int unsigned ENTRY_RST_MC  = 2;
	// Final reset after oscillator recovery, in machine cycles
	localparam int unsigned FINAL_RST_MC  = 2;
	// RC clocks the oscillator monitor waits after the crystal is good
	localparam int unsigned OSC_OK_CLKS   = 768;
	localparam int unsigned CNT_W         = 10;
	// Pin state codes for strobes and ports
	localparam logic        STROBE_IDLE   = 1'b1;
	localparam logic        STROBE_SWPD   = 1'b0;
	localparam logic        STROBE_RESET  = 1'b1;
	localparam logic [7:0]  PORT_RESET    = 8'hFF;

	typedef enum logic [2:0] {
		HPDS_RUN,
		HPDS_ENTRY_RST,
		HPDS_PULSE_RST,
		HPDS_FLOAT,
		HPDS_OSC_WAIT,
		HPDS_FINAL_RST
	} hpds_state_t;

endpackage

// ==== hdl/hpds_mc_timer.sv ====
// Machine cycle timer: one pulse per machine cycle
`timescale 1ns/1ps
module hpds_mc_timer #(
	parameter int unsigned CLKS = hpds_pkg::MC_CLKS
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	// Machine cycle strobe
	output logic      mc_tick_o
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	wire        wrap = (cnt_q == 8'(CLKS - 1));

	assign cnt_d     = wrap ? 8'h00 : cnt_q + 8'h01;
	assign mc_tick_o = wrap;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 8'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end

endmodule

// ==== hdl/hpds_osc_monitor.sv ====
// Oscillator failure monitor: holds reset until crystal is stable
`timescale 1ns/1ps
module hpds_osc_monitor #(
	parameter int unsigned OK_CLKS = hpds_pkg::OSC_OK_CLKS
) (
	// Clock and reset
	input  wire logic core_clk_i,
	input  wire logic rst_b_i,
	// Oscillator status
	input  wire logic xtal_running_i,
	input  wire logic enable_i,
	// Result
	output logic      xtal_ok_o
);

	localparam int unsigned W = hpds_pkg::CNT_W;

	logic [W-1:0] cnt_q;
	wire          done = (cnt_q == W'(OK_CLKS));

	assign xtal_ok_o = done;

	// A running crystal must be seen for OK_CLKS clocks; any drop restarts
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= '0;
		end else if (!enable_i || !xtal_running_i) begin
			cnt_q <= '0;
		end else if (!done) begin
			cnt_q <= cnt_q + 1'b1;
		end
	end

endmodule

// ==== hdl/hpds_core.sv ====
// Hardware power down sequencer and power-saving pin control
`timescale 1ns/1ps
module hpds_core #(
	parameter int unsigned ENTRY_MC = hpds_pkg::ENTRY_RST_MC,
	parameter int unsigned FINAL_MC = hpds_pkg::FINAL_RST_MC,
	parameter int unsigned OSC_CLKS = hpds_pkg::OSC_OK_CLKS
) (
	// Clock and external reset (RESET pin, active low)
	input  wire logic       core_clk_i,
	input  wire logic       rst_b_i,
	// Power down pins
	input  wire logic       hw_powerdown_n_i,
	input  wire logic       pwrsave_en_wdt_autostart_i,
	// Core state
	input  wire logic       idle_mode_i,
	input  wire logic       sw_pd_mode_i,
	input  wire logic       ext_code_i,
	input  wire logic [7:0] p0_data_i,
	input  wire logic [7:0] p2_data_i,
	input  wire logic [7:0] p2_addr_i,
	input  wire logic       ale_run_i,
	input  wire logic       prog_store_strobe_run_i,
	input  wire logic       xtal_running_i,
	// Strobes
	output logic            ale_o,
	output logic            ale_oe_o,
	output logic            prog_store_strobe_o,
	output logic            prog_store_strobe_oe_o,
	// Ports 0 and 2
	output logic [7:0]      p0_o,
	output logic            p0_oe_o,
	output logic [7:0]      p2_o,
	output logic            p2_oe_o,
	// Other ports and input gating
	output logic            ports_float_o,
	output logic            port_in_en_o,
	output logic            pwrsave_pullup_en_o,
	// Software mode permission
	output logic            sw_modes_allowed_o,
	// Oscillators and clock
	output logic            xtal_osc_en_o,
	output logic            rc_osc_en_o,
	output logic            clk_sel_xtal_o,
	// Chip reset and status
	output logic            int_rst_o,
	output logic            wdt_stop_o,
	output logic            wdt_status_flag_clr_o,
	output logic            osc_failure_monitor_o,
	output logic            osc_status_set_o,
	output logic            wdt_autostart_o,
	output logic            wdt_start_o
);

	hpds_pkg::hpds_state_t state_q;
	hpds_pkg::hpds_state_t state_d;

	logic       mc_tick;
	logic       xtal_ok;
	logic       pd_sample_q;
	logic [1:0] mc_cnt_q;
	logic [1:0] mc_cnt_d;
	logic       autostart_q;
	logic       strap_done_q;
	logic       restart_q;

	// Machine cycle strobe
	hpds_mc_timer #(
		.CLKS (hpds_pkg::MC_CLKS)
	) u_mc (
		.core_clk_i (core_clk_i),
		.rst_b_i    (rst_b_i),
		.mc_tick_o  (mc_tick)
	);

	// Oscillator recovery monitor
	hpds_osc_monitor #(
		.OK_CLKS (OSC_CLKS)
	) u_osc (
		.core_clk_i     (core_clk_i),
		.rst_b_i        (rst_b_i),
		.xtal_running_i (xtal_running_i),
		.enable_i       (state_q == hpds_pkg::HPDS_OSC_WAIT),
		.xtal_ok_o      (xtal_ok)
	);

	// Pin sample, taken once per machine cycle
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pd_sample_q <= 1'b0;
		end else if (mc_tick) begin
			pd_sample_q <= !hw_powerdown_n_i;
		end
	end

	wire pd_active  = pd_sample_q;
	wire mc_last    = (mc_cnt_q == 2'(ENTRY_MC - 1));
	wire fin_last   = (mc_cnt_q == 2'(FINAL_MC - 1));
	wire in_reset   = (state_q == hpds_pkg::HPDS_ENTRY_RST) || (state_q == hpds_pkg::HPDS_PULSE_RST)
		|| (state_q == hpds_pkg::HPDS_OSC_WAIT) || (state_q == hpds_pkg::HPDS_FINAL_RST);
	wire floating   = (state_q == hpds_pkg::HPDS_FLOAT);
	wire pin_pd_now = !hw_powerdown_n_i;

	// Sequencer; the external reset is the async reset and so always overrides it
	always_comb begin
		state_d  = state_q;
		mc_cnt_d = mc_cnt_q;
		unique case (state_q)
			hpds_pkg::HPDS_RUN: begin
				if (mc_tick && pd_active) begin
					state_d  = hpds_pkg::HPDS_ENTRY_RST;
					mc_cnt_d = 2'd0;
				end
			end
			hpds_pkg::HPDS_ENTRY_RST: begin
				if (mc_tick) begin
					mc_cnt_d = mc_cnt_q + 2'd1;
					if (mc_last) begin
						// Pin still sampled low: go down, else a plain reset pulse
						state_d  = pd_active ? hpds_pkg::HPDS_FLOAT : hpds_pkg::HPDS_RUN;
						mc_cnt_d = 2'd0;
					end
				end
			end
			hpds_pkg::HPDS_PULSE_RST: begin
				state_d = hpds_pkg::HPDS_RUN;
			end
			hpds_pkg::HPDS_FLOAT: begin
				// Oscillators stopped: the machine tick is not trusted, watch the pin
				if (!pin_pd_now) begin
					state_d = hpds_pkg::HPDS_OSC_WAIT;
				end
			end
			hpds_pkg::HPDS_OSC_WAIT: begin
				if (xtal_ok) begin
					state_d  = hpds_pkg::HPDS_FINAL_RST;
					mc_cnt_d = 2'd0;
				end
			end
			hpds_pkg::HPDS_FINAL_RST: begin
				if (mc_tick) begin
					mc_cnt_d = mc_cnt_q + 2'd1;
					if (fin_last) begin
						state_d  = hpds_pkg::HPDS_RUN;
						mc_cnt_d = 2'd0;
					end
				end
			end
			default: begin
				state_d = hpds_pkg::HPDS_RUN;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q  <= hpds_pkg::HPDS_RUN;
			mc_cnt_q <= 2'd0;
		end else begin
			state_q  <= state_d;
			mc_cnt_q <= mc_cnt_d;
		end
	end

	// Auto-start strap caught on the first clock after hardware reset release only
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			strap_done_q <= 1'b0;
			autostart_q  <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			autostart_q  <= pwrsave_en_wdt_autostart_i;
		end
	end

	// One-cycle marker at the end of a restart from hardware power down
	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			restart_q <= 1'b0;
		end else begin
			restart_q <= (state_q == hpds_pkg::HPDS_FINAL_RST) && (state_d == hpds_pkg::HPDS_RUN);
		end
	end

	// Software mode pin states; reset and float take precedence
	wire swpd = sw_pd_mode_i && !idle_mode_i;
	wire idle = idle_mode_i;
	wire strobe_val = idle ? hpds_pkg::STROBE_IDLE : (swpd ? hpds_pkg::STROBE_SWPD : 1'b0);
	wire sw_mode = idle || swpd;

	always_ff @(posedge core_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ale_o               <= hpds_pkg::STROBE_RESET;
			prog_store_strobe_o <= hpds_pkg::STROBE_RESET;
			p0_o                <= hpds_pkg::PORT_RESET;
			p2_o                <= hpds_pkg::PORT_RESET;
		end else if (in_reset || floating) begin
			ale_o               <= hpds_pkg::STROBE_RESET;
			prog_store_strobe_o <= hpds_pkg::STROBE_RESET;
			p0_o                <= hpds_pkg::PORT_RESET;
			p2_o                <= hpds_pkg::PORT_RESET;
		end else begin
			ale_o               <= sw_mode ? strobe_val : ale_run_i;
			prog_store_strobe_o <= sw_mode ? strobe_val : prog_store_strobe_run_i;
			p0_o                <= p0_data_i;
			p2_o                <= (ext_code_i && idle) ? p2_addr_i : p2_data_i;
		end
	end

	assign ale_oe_o               = !floating;
	assign prog_store_strobe_oe_o = !floating;
	assign p0_oe_o                = !floating && !(ext_code_i && sw_mode && !in_reset);
	assign p2_oe_o                = !floating;
	assign ports_float_o          = floating;
	assign port_in_en_o           = !floating;
	assign pwrsave_pullup_en_o    = !floating;
	assign sw_modes_allowed_o     = !pwrsave_en_wdt_autostart_i;
	assign xtal_osc_en_o          = !floating;
	assign rc_osc_en_o            = !floating;
	assign clk_sel_xtal_o         = (state_q != hpds_pkg::HPDS_OSC_WAIT) && !floating;
	assign int_rst_o              = in_reset || floating;
	assign wdt_stop_o             = (state_q == hpds_pkg::HPDS_ENTRY_RST);
	assign wdt_status_flag_clr_o  = (state_q == hpds_pkg::HPDS_ENTRY_RST);
	assign osc_failure_monitor_o  = (state_q == hpds_pkg::HPDS_OSC_WAIT);
	assign osc_status_set_o       = restart_q;
	assign wdt_autostart_o        = autostart_q;
	assign wdt_start_o            = restart_q && autostart_q;

	// Assertions
	sequence entry_seq;
		state_q == hpds_pkg::HPDS_RUN && mc_tick && pd_active;
	endsequence

	AST_ENTRY_RESET: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		entry_seq |=> int_rst_o && wdt_stop_o)
		else $error("entry reset not started");

	AST_SAMPLE_ON_TICK: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!mc_tick |=> $stable(pd_sample_q))
		else $error("pin sampled off machine cycle");

	AST_FLOAT_PINS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		floating |-> !p0_oe_o && !p2_oe_o && !ale_oe_o && !prog_store_strobe_oe_o && !port_in_en_o)
		else $error("pins driven while floating");

	AST_OSC_OFF: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		floating |-> !xtal_osc_en_o && !rc_osc_en_o && !pwrsave_pullup_en_o)
		else $error("oscillator on in power down");

	AST_WAKE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		floating && hw_powerdown_n_i |=> state_q == hpds_pkg::HPDS_OSC_WAIT && xtal_osc_en_o && rc_osc_en_o)
		else $error("no start-up on pin release");

	AST_OSC_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		osc_failure_monitor_o |-> int_rst_o && !clk_sel_xtal_o)
		else $error("reset released before crystal");

	AST_RESTART_FLAG: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		state_q == hpds_pkg::HPDS_FINAL_RST && state_d == hpds_pkg::HPDS_RUN |=> osc_status_set_o)
		else $error("status flag not set on restart");

	AST_AUTOSTART: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		osc_status_set_o |-> wdt_start_o == autostart_q)
		else $error("watchdog auto-start wrong");

	AST_STRAP_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		strap_done_q |=> $stable(autostart_q))
		else $error("auto-start changed after reset");

	AST_SW_MODES: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		sw_modes_allowed_o == !pwrsave_en_wdt_autostart_i)
		else $error("software mode gate wrong");

	// Software mode and running pin states, only outside reset and float
	AST_STROBE_IDLE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!in_reset && !floating && idle_mode_i
		|=> ale_o == hpds_pkg::STROBE_IDLE && prog_store_strobe_o == hpds_pkg::STROBE_IDLE)
		else $error("strobes not high in idle");

	AST_STROBE_SWPD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!in_reset && !floating && sw_pd_mode_i && !idle_mode_i
		|=> ale_o == hpds_pkg::STROBE_SWPD && prog_store_strobe_o == hpds_pkg::STROBE_SWPD)
		else $error("strobes not low in power down");

	AST_P0_FLOAT: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!in_reset && !floating && ext_code_i && (idle_mode_i || sw_pd_mode_i) |-> !p0_oe_o)
		else $error("port 0 driven in a software mode");

	AST_P2_ADDR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!in_reset && !floating && ext_code_i && idle_mode_i |=> p2_o == $past(p2_addr_i))
		else $error("port 2 not showing address in idle");

	AST_RUN_STROBES: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!in_reset && !floating && !idle_mode_i && !sw_pd_mode_i
		|=> ale_o == $past(ale_run_i) && prog_store_strobe_o == $past(prog_store_strobe_run_i))
		else $error("strobes not following the core");

	// Two machine cycles of twelve clocks each
	AST_ENTRY_LEN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$rose(wdt_stop_o) |-> ##23 wdt_stop_o ##1 !wdt_stop_o)
		else $error("entry reset length wrong");

	AST_PINS_IN_RESET: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		in_reset && $past(in_reset) |-> ale_o == hpds_pkg::STROBE_RESET
		&& prog_store_strobe_o == hpds_pkg::STROBE_RESET
		&& p0_o == hpds_pkg::PORT_RESET && p2_o == hpds_pkg::PORT_RESET)
		else $error("pins not at reset state");

	AST_ENTRY_FLAGS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		entry_seq |=> wdt_status_flag_clr_o)
		else $error("watchdog flag not cleared on entry");

	AST_GO_DOWN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		state_q == hpds_pkg::HPDS_ENTRY_RST && mc_tick && mc_last && pd_active
		|=> floating && !xtal_osc_en_o && !rc_osc_en_o)
		else $error("oscillators not stopped after entry reset");

	AST_STAY_DOWN: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		floating && !hw_powerdown_n_i |=> floating)
		else $error("left power down while pin active");

	AST_PULSE_RESUME: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		state_q == hpds_pkg::HPDS_ENTRY_RST && mc_tick && mc_last && !pd_active
		|=> state_q == hpds_pkg::HPDS_RUN && xtal_osc_en_o && rc_osc_en_o)
		else $error("short pulse did not resume");

	AST_RELEASE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		$rose(osc_status_set_o) |-> !int_rst_o && clk_sel_xtal_o)
		else $error("restart without release to crystal");

endmodule

// ==== tb/hpds_pd_partner.sv ====
// Partner model: power-management source on the power-down pin, plus the crystal
`timescale 1ns/1ps
module hpds_pd_partner #(
	parameter int START_CLKS = 40
) (
	// Clock
	input  wire logic core_clk_i,
	// Crystal enable from the sequencer
	input  wire logic xtal_osc_en_i,
	// Pins toward the sequencer
	output logic      hw_powerdown_n_o,
	output logic      xtal_running_o
);
	int run_cnt = START_CLKS;

	initial begin
		hw_powerdown_n_o = 1'b1;
	end

	// Crystal needs time after enable and stops at once when disabled
	always @(posedge core_clk_i) begin
		run_cnt <= xtal_osc_en_i ? ((run_cnt < START_CLKS) ? run_cnt + 1 : run_cnt) : 0;
	end
	assign xtal_running_o = (run_cnt >= START_CLKS);

	// Hold the pin low for n clocks; n of zero leaves it low
	task automatic pd_low(input int n);
		@(posedge core_clk_i);
		#1 hw_powerdown_n_o = 1'b0;
		repeat (n) @(posedge core_clk_i);
		if (n > 0) #1 hw_powerdown_n_o = 1'b1;
	endtask

	task automatic pd_high;
		@(posedge core_clk_i);
		#1 hw_powerdown_n_o = 1'b1;
	endtask
endmodule

// ==== tb/hw_power_down_sequencer_test.sv ====
// Self-checking bench for the hardware power down sequencer
`timescale 1ns/1ps
module hw_power_down_sequencer_test;
	logic       core_clk_i = 0, rst_b_i = 0, pwrsave_en_wdt_autostart_i = 1, idle_mode_i = 0, sw_pd_mode_i = 0;
	logic       ext_code_i = 0, ale_run_i = 0, prog_store_strobe_run_i = 0, hw_powerdown_n_i, xtal_running_i;
	logic [7:0] p0_data_i = 8'h00, p2_data_i = 8'h00, p2_addr_i = 8'h00, p0_o, p2_o;
	logic       ale_o, ale_oe_o, prog_store_strobe_o, prog_store_strobe_oe_o, p0_oe_o, p2_oe_o, ports_float_o;
	logic       port_in_en_o, pwrsave_pullup_en_o, sw_modes_allowed_o, xtal_osc_en_o, rc_osc_en_o, clk_sel_xtal_o;
	logic       int_rst_o, wdt_stop_o, wdt_status_flag_clr_o, osc_failure_monitor_o, osc_status_set_o;
	logic       wdt_autostart_o, wdt_start_o;
	int         error_cnt = 0, num_checks = 0, n, len;

	always #10 core_clk_i = ~core_clk_i;

	// Short crystal-good count keeps the restart walk brief
	hpds_core #(.OSC_CLKS(8)) dut (.core_clk_i, .rst_b_i, .hw_powerdown_n_i, .pwrsave_en_wdt_autostart_i,
		.idle_mode_i, .sw_pd_mode_i, .ext_code_i, .p0_data_i, .p2_data_i, .p2_addr_i, .ale_run_i,
		.prog_store_strobe_run_i, .xtal_running_i, .ale_o, .ale_oe_o, .prog_store_strobe_o,
		.prog_store_strobe_oe_o, .p0_o, .p0_oe_o, .p2_o, .p2_oe_o, .ports_float_o, .port_in_en_o,
		.pwrsave_pullup_en_o,
		.sw_modes_allowed_o, .xtal_osc_en_o, .rc_osc_en_o, .clk_sel_xtal_o, .int_rst_o, .wdt_stop_o,
		.wdt_status_flag_clr_o, .osc_failure_monitor_o, .osc_status_set_o, .wdt_autostart_o, .wdt_start_o);

	hpds_pd_partner #(.START_CLKS(40)) partner (.core_clk_i, .xtal_osc_en_i(xtal_osc_en_o),
		.hw_powerdown_n_o(hw_powerdown_n_i), .xtal_running_o(xtal_running_i));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic finish_test;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge core_clk_i);
		#1;
	endtask

	// Port 2 model: address only in idle with external code
	function automatic logic [7:0] exp_p2;
		return (ext_code_i && idle_mode_i) ? p2_addr_i : p2_data_i;
	endfunction

	function automatic logic sig(input int c);
		case (c)
			0: return int_rst_o;
			1: return xtal_osc_en_o;
			default: return osc_status_set_o;
		endcase
	endfunction

	task automatic wait_for(input int c, input logic v);
		n = 0;
		while (sig(c) !== v && n < 300) begin
			tick(1);
			n++;
		end
		if (n == 300) error_cnt++;
	endtask

	// Entry reset: measure its length and look at the pins while it runs
	task automatic entry_reset;
		wait_for(0, 1'b1);
		// Registered pins reach their reset state one clock after the reset level
		tick(1);
		check({ale_o, prog_store_strobe_o, wdt_stop_o, wdt_status_flag_clr_o}, 4'hF);
		check(p2_o, 8'hFF);
		len = 1;
		// Watchdog stop marks the entry reset alone; int_rst_o stays high while floating
		while (wdt_stop_o === 1'b1 && len < 100) begin
			tick(1);
			len++;
		end
		check(len, hpds_pkg::ENTRY_RST_MC * hpds_pkg::MC_CLKS);
	endtask

	initial begin
		n = $urandom(65583);
		tick(6);
		rst_b_i = 1'b1;
		tick(2);
		for (int i = 0; i < 60; i++) begin
			{idle_mode_i, sw_pd_mode_i, ext_code_i, ale_run_i, prog_store_strobe_run_i} = 5'($urandom);
			{p0_data_i, p2_data_i, p2_addr_i} = 24'($urandom);
			pwrsave_en_wdt_autostart_i = i[0];
			tick(2);
			check(sw_modes_allowed_o, !pwrsave_en_wdt_autostart_i);
			check(wdt_autostart_o, 1'b1);
			if (!idle_mode_i && !sw_pd_mode_i) check({ale_o, prog_store_strobe_o}, {ale_run_i, prog_store_strobe_run_i});
			if (!i[0] && (idle_mode_i || sw_pd_mode_i)) begin
				check({ale_o, prog_store_strobe_o}, {2{idle_mode_i}});
				check(p0_oe_o, !ext_code_i);
				check(p2_o, exp_p2());
				if (!ext_code_i) check(p0_o, p0_data_i);
			end
		end
		{idle_mode_i, sw_pd_mode_i} = 2'b00;
		// One sampled low: reset, then straight back to running
		partner.pd_low(12);
		entry_reset();
		check({xtal_osc_en_o, rc_osc_en_o, ports_float_o}, 3'b110);
		// Held low: reset, then everything stops and floats
		pwrsave_en_wdt_autostart_i = 1'b1;
		partner.pd_low(0);
		entry_reset();
		check({xtal_osc_en_o, rc_osc_en_o}, 2'b00);
		check({ale_oe_o, prog_store_strobe_oe_o, p0_oe_o, p2_oe_o}, 4'h0);
		check({ports_float_o, port_in_en_o}, 2'b10);
		check({pwrsave_pullup_en_o, sw_modes_allowed_o}, 2'b00);
		tick(100);
		check({ports_float_o, xtal_osc_en_o}, 2'b10);
		partner.pd_high();
		tick(2);
		check({ale_oe_o, p0_oe_o, p2_oe_o, ports_float_o, p2_o[0]}, 5'b11101);
		check({xtal_osc_en_o, rc_osc_en_o}, 2'b11);
		check({osc_failure_monitor_o, int_rst_o, clk_sel_xtal_o}, 3'b110);
		wait_for(2, 1'b1);
		check(osc_status_set_o, 1'b1);
		check(wdt_start_o, 1'b1);
		check({int_rst_o, clk_sel_xtal_o}, 2'b01);
		// External reset in mid power down ends it at once
		partner.pd_low(0);
		wait_for(1, 1'b0);
		pwrsave_en_wdt_autostart_i = 1'b0;
		rst_b_i = 1'b0;
		#2;
		check({xtal_osc_en_o, p0_oe_o, ports_float_o, int_rst_o}, 4'b1100);
		partner.pd_high();
		tick(3);
		rst_b_i = 1'b1;
		tick(3);
		check(wdt_autostart_o, 1'b0);
		finish_test();
	end

	initial begin
		#(20 * 6000);
		error_cnt++;
		finish_test();
	end
endmodule
